// [sspi_status_prescale_irq.sv]
// Status flags, bit-clock prescaler and interrupt conditions of the serial
// port, as an APB slave.
// Assumes the frame engine and FIFOs run on pclk and report their levels,
// a frame-received strobe, a FIFO-read strobe and a slave bit tick.
`timescale 1ns/1ps
module sspi_status_prescale_irq
  import sspi_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame engine and FIFO side
  input wire sspi_fifo_stat_t fifo_stat,
  input wire logic slave_mode,
  input wire logic slave_bit_tick,
  input wire logic rx_frame_done,
  input wire logic rx_fifo_read,
  // Bit clock and event outputs
  output logic bit_clk_en,
  output logic rx_overwrite,
  output logic irq
);

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic addr_is(input logic [31:0] addr, input logic [31:0] off);
    addr_is = (addr == off);
  endfunction : addr_is

  wire logic hit_ctrl0 = addr_is(paddr, SSPI_CTRL0_OFF);
  wire logic hit_stat = addr_is(paddr, SSPI_STAT_OFF);
  wire logic hit_presc = addr_is(paddr, SSPI_PRESC_OFF);
  wire logic hit_mask = addr_is(paddr, SSPI_MASK_OFF);
  wire logic hit_raw = addr_is(paddr, SSPI_RAW_OFF);
  wire logic hit_masked = addr_is(paddr, SSPI_MASKED_OFF);
  wire logic hit_clr = addr_is(paddr, SSPI_CLR_OFF);
  wire logic hit_any = hit_ctrl0 | hit_stat | hit_presc | hit_mask | hit_raw
                       | hit_masked | hit_clr;

  wire logic setup_ph = psel & ~penable;
  wire logic access_ph = psel & penable;
  wire logic wr_acc = access_ph & pwrite & hit_any;
  wire logic wr_ctrl0 = wr_acc & hit_ctrl0;
  wire logic wr_presc = wr_acc & hit_presc;
  wire logic wr_mask = wr_acc & hit_mask;
  wire logic wr_clr = wr_acc & hit_clr;

  // Zero wait states; an unmapped address is refused with an error.
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_any;

  // ==========================================================================
  // Software registers
  // ==========================================================================
  logic [7:0] prescale_divisor_r;
  logic [7:0] clock_rate_factor_r;
  logic [3:0] interrupt_enable_mask_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prescale_divisor_r <= SSPI_PRESC_RST;
      clock_rate_factor_r <= SSPI_RATE_RST;
      interrupt_enable_mask_r <= SSPI_MASK_RST;
    end
    else
    begin
      if (wr_presc)
        prescale_divisor_r <= {pwdata[7:1], 1'b0};
      if (wr_ctrl0)
        clock_rate_factor_r <= pwdata[SSPI_RATE_LSB +: 8];
      if (wr_mask)
        interrupt_enable_mask_r <= pwdata[3:0];
    end
  end

  // ==========================================================================
  // Live status flags
  // ==========================================================================
  wire logic tx_fifo_empty = (fifo_stat.tx_level == 4'h0);
  wire logic tx_fifo_not_full = (fifo_stat.tx_level != SSPI_FIFO_FULL);
  wire logic rx_fifo_not_empty = (fifo_stat.rx_level != 4'h0);
  wire logic rx_fifo_full = (fifo_stat.rx_level == SSPI_FIFO_FULL);
  wire logic controller_busy = fifo_stat.frame_active | ~tx_fifo_empty;

  // The status word has no storage, so a write can never disturb it.
  wire logic [31:0] stat_word = {27'h0, controller_busy, rx_fifo_full,
                                 rx_fifo_not_empty, tx_fifo_not_full, tx_fifo_empty};

  // ==========================================================================
  // Prescaler and bit clock
  // ==========================================================================
  // A divisor below two never ticks, so an unprogrammed prescaler stalls
  // the bit clock instead of running it at a wrong rate.
  logic [7:0] presc_cnt_r;
  logic [7:0] rate_cnt_r;
  logic bit_clk_en_r;

  wire logic presc_ok = (prescale_divisor_r >= SSPI_PRESC_MIN);
  wire logic presc_run = presc_ok & ~slave_mode;
  wire logic presc_wrap = presc_run & (presc_cnt_r == prescale_divisor_r - 8'h01);
  wire logic rate_wrap = presc_wrap & (rate_cnt_r == clock_rate_factor_r);

  logic [7:0] presc_cnt_nxt;
  logic [7:0] rate_cnt_nxt;
  assign presc_cnt_nxt = (!presc_run || presc_wrap) ? 8'h00 : presc_cnt_r + 8'h01;
  assign rate_cnt_nxt = !presc_run ? 8'h00 :
                        rate_wrap ? 8'h00 :
                        presc_wrap ? rate_cnt_r + 8'h01 : rate_cnt_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_cnt_r <= 8'h00;
      rate_cnt_r <= 8'h00;
      bit_clk_en_r <= 1'b0;
    end
    else
    begin
      presc_cnt_r <= presc_cnt_nxt;
      rate_cnt_r <= rate_cnt_nxt;
      bit_clk_en_r <= rate_wrap;
    end
  end

  assign bit_clk_en = bit_clk_en_r;

  // ==========================================================================
  // Receive time-out
  // ==========================================================================
  // Master counts its own bit clock, slave counts the engine's bit tick, so
  // the period is 32 bits in either mode.
  logic [5:0] tmo_cnt_r;
  logic [5:0] tmo_cnt_nxt;
  wire logic bit_tick = slave_mode ? slave_bit_tick : bit_clk_en_r;
  wire logic tmo_hold = ~rx_fifo_not_empty | rx_fifo_read;
  wire logic tmo_hit = ~tmo_hold & bit_tick & (tmo_cnt_r == SSPI_TMO_BITS - 6'h01);

  assign tmo_cnt_nxt = tmo_hold ? 6'h00 :
                       (bit_tick && tmo_cnt_r != SSPI_TMO_BITS) ? tmo_cnt_r + 6'h01 :
                       tmo_cnt_r;

  // ==========================================================================
  // Interrupt conditions
  // ==========================================================================
  logic overrun_raw_r;
  logic timeout_raw_r;
  logic rx_overwrite_r;
  wire logic overrun_set = rx_frame_done & rx_fifo_full;
  wire logic overrun_clear = wr_clr & pwdata[SSPI_IRQ_OVR];
  wire logic timeout_clear = wr_clr & pwdata[SSPI_IRQ_TMO];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmo_cnt_r <= 6'h00;
      overrun_raw_r <= 1'b0;
      timeout_raw_r <= 1'b0;
      rx_overwrite_r <= 1'b0;
    end
    else
    begin
      tmo_cnt_r <= tmo_cnt_nxt;
      rx_overwrite_r <= overrun_set;
      // A set in the same cycle as a clear wins.
      if (overrun_set)
        overrun_raw_r <= 1'b1;
      else if (overrun_clear)
        overrun_raw_r <= 1'b0;
      if (tmo_hit)
        timeout_raw_r <= 1'b1;
      else if (timeout_clear)
        timeout_raw_r <= 1'b0;
    end
  end

  assign rx_overwrite = rx_overwrite_r;

  sspi_irq_t raw_flags;
  assign raw_flags.overrun = overrun_raw_r;
  assign raw_flags.timeout = timeout_raw_r;
  assign raw_flags.rx_half = (fifo_stat.rx_level >= SSPI_FIFO_HALF);
  assign raw_flags.tx_half = (fifo_stat.tx_level <= SSPI_FIFO_HALF);

  wire logic [3:0] raw_vec = raw_flags;
  logic [3:0] masked_vec;

  genvar gi;
  generate
    for (gi = 0; gi < SSPI_NUM_IRQ; gi++)
    begin : g_mask
      assign masked_vec[gi] = raw_vec[gi] & interrupt_enable_mask_r[gi];
    end
  endgenerate

  logic irq_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= |masked_vec;
  end
  assign irq = irq_r;

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Read data is captured in the setup cycle and held for the access cycle.
  logic [31:0] rd_mux;
  assign rd_mux = hit_stat ? stat_word :
                  hit_presc ? {24'h0, prescale_divisor_r} :
                  hit_ctrl0 ? {16'h0, clock_rate_factor_r, 8'h00} :
                  hit_mask ? {28'h0, interrupt_enable_mask_r} :
                  hit_raw ? {28'h0, raw_vec} :
                  hit_masked ? {28'h0, masked_vec} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_ph)
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
  end

endmodule : sspi_status_prescale_irq

// [sspi_pkg.sv]
// Constants, register map and carrier types of the serial port status,
// prescaler and interrupt-condition block.
// Assumes a 32-bit APB register bus and FIFOs of eight entries outside the block.
package sspi_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [31:0] SSPI_CTRL0_OFF = 32'h4004_0000;
  localparam logic [31:0] SSPI_STAT_OFF = 32'h4004_000C;
  localparam logic [31:0] SSPI_PRESC_OFF = 32'h4004_0010;
  localparam logic [31:0] SSPI_MASK_OFF = 32'h4004_0014;
  localparam logic [31:0] SSPI_RAW_OFF = 32'h4004_0018;
  localparam logic [31:0] SSPI_MASKED_OFF = 32'h4004_001C;
  localparam logic [31:0] SSPI_CLR_OFF = 32'h4004_0020;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int SSPI_ST_TX_EMPTY = 0;
  localparam int SSPI_ST_TX_NOT_FULL = 1;
  localparam int SSPI_ST_RX_NOT_EMPTY = 2;
  localparam int SSPI_ST_RX_FULL = 3;
  localparam int SSPI_ST_BUSY = 4;
  localparam int SSPI_RATE_LSB = 8;
  localparam int SSPI_IRQ_OVR = 0;
  localparam int SSPI_IRQ_TMO = 1;
  localparam int SSPI_IRQ_RXH = 2;
  localparam int SSPI_IRQ_TXH = 3;
  localparam int SSPI_NUM_IRQ = 4;
  localparam logic [7:0] SSPI_PRESC_RST = 8'h00;
  localparam logic [7:0] SSPI_RATE_RST = 8'h00;
  localparam logic [3:0] SSPI_MASK_RST = 4'h0;
  localparam logic [7:0] SSPI_PRESC_MIN = 8'h02;

  // ==========================================================================
  // FIFO geometry and timing counts
  // ==========================================================================
  localparam int SSPI_FIFO_DEPTH = 8;
  localparam logic [3:0] SSPI_FIFO_FULL = 4'h8;
  localparam logic [3:0] SSPI_FIFO_HALF = 4'h4;
  localparam logic [5:0] SSPI_TMO_BITS = 6'h20;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [3:0] tx_level;
    logic [3:0] rx_level;
    logic frame_active;
  } sspi_fifo_stat_t;

  typedef struct packed {
    logic tx_half;
    logic rx_half;
    logic timeout;
    logic overrun;
  } sspi_irq_t;

endpackage : sspi_pkg

// [sspi_monitor.sv]
// Port checker of the status, prescaler and interrupt block.
// Bound to the block; it sees only the block's ports.
`timescale 1ns/1ps
module sspi_monitor
  import sspi_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Serial side
  input wire sspi_fifo_stat_t fifo_stat,
  input wire logic slave_mode,
  input wire logic rx_frame_done,
  input wire logic bit_clk_en,
  input wire logic rx_overwrite,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = psel && penable && !pwrite;
  wire [3:0] tl = fifo_stat.tx_level;
  wire [3:0] rl = fifo_stat.rx_level;
  wire [4:0] st = {fifo_stat.frame_active || |tl, rl == 4'h8, |rl, tl != 4'h8, tl == 4'h0};
  wire [1:0] hf = {tl <= 4'h4, rl >= 4'h4};
  sequence s_full; rx_frame_done && rl == 4'h8; endsequence
  sequence s_slv; slave_mode ##1 slave_mode; endsequence
  property p_ovw; s_full |=> rx_overwrite; endproperty
  a_ovw: assert property (p_ovw) else $error("no overwrite pulse");
  property p_ovc; rx_overwrite |-> $past(rx_frame_done && rl == 4'h8); endproperty
  a_ovc: assert property (p_ovc) else $error("stray overwrite");
  property p_st; rd && paddr == SSPI_STAT_OFF |-> prdata == {27'h0, $past(st)}; endproperty
  a_st: assert property (p_st) else $error("status word");
  property p_ps; rd && paddr == SSPI_PRESC_OFF |-> !prdata[0]; endproperty
  a_ps: assert property (p_ps) else $error("divisor bit 0 set");
  property p_raw; rd && paddr == SSPI_RAW_OFF |-> prdata[31:2] == {28'h0, $past(hf)}; endproperty
  a_raw: assert property (p_raw) else $error("raw half levels");
  property p_slv; s_slv |-> !bit_clk_en; endproperty
  a_slv: assert property (p_slv) else $error("bit tick in slave");
  property p_clk; bit_clk_en |=> !bit_clk_en; endproperty
  a_clk: assert property (p_clk) else $error("bit ticks too close");
  property p_irq; psel && penable && pwrite && paddr == SSPI_MASK_OFF && pwdata[3:0] == 4'h0
    |-> ##2 !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq with no enable");
endmodule : sspi_monitor
bind sspi_status_prescale_irq sspi_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .fifo_stat(fifo_stat), .slave_mode(slave_mode), .rx_frame_done(rx_frame_done),
  .bit_clk_en(bit_clk_en), .rx_overwrite(rx_overwrite), .irq(irq));

// [sspi_peer.sv]
// Far-side model: receive FIFO level, frame and read strobes, slave ticks.
// Assumes the bench asks for pushes and pops as one-cycle pulses.
`timescale 1ns/1ps
module sspi_peer
  import sspi_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests
  input wire logic push,
  input wire logic pop,
  input wire logic active,
  input wire logic [3:0] tx_level,
  // Block side
  output sspi_fifo_stat_t fifo_stat,
  output logic rx_frame_done,
  output logic rx_fifo_read,
  output logic slave_bit_tick
);
  logic [3:0] rx_r;
  logic [3:0] div_r;
  assign fifo_stat = '{tx_level: tx_level, rx_level: rx_r, frame_active: active};
  assign rx_frame_done = push;
  assign rx_fifo_read = pop && rx_r != 4'h0;
  // The external master is kept to one bit every twelve clocks, its fastest.
  assign slave_bit_tick = div_r == 4'hB;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_r <= 4'h0;
      div_r <= 4'h0;
    end
    else
    begin
      div_r <= (div_r == 4'hB) ? 4'h0 : div_r + 4'h1;
      // A frame landing on a full FIFO replaces the last entry, so the level holds.
      if (push && rx_r != SSPI_FIFO_FULL)
        rx_r <= rx_r + 4'h1;
      else if (rx_fifo_read)
        rx_r <= rx_r - 4'h1;
    end
  end
endmodule : sspi_peer

// [spi_status_prescale_irq_tb.sv]
// Random bench of the status, prescaler and interrupt block.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/1ps
module spi_status_prescale_irq_tb
  import sspi_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slave_mode = 1'b0, push = 1'b0, pop = 1'b0, act = 1'b0, ovr = 1'b0;
  logic [3:0] txl = 4'h0, msk;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, seed = 32'h53, rd, prdata;
  logic pready, pslverr, sbt, rfd, rfr, bce, ovw, irq, perr;
  sspi_fifo_stat_t fst;
  int num_errors = 0, checks = 0, rxn = 0, n;
  logic [31:0] ra [5] = '{SSPI_STAT_OFF, SSPI_PRESC_OFF, SSPI_MASK_OFF, SSPI_RAW_OFF,
    32'h4004_0030};
  logic [31:0] re [5] = '{32'h3, 32'h0, 32'h0, 32'h8, 32'h0};
  sspi_status_prescale_irq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_stat(fst), .slave_mode(slave_mode), .slave_bit_tick(sbt),
    .rx_frame_done(rfd), .rx_fifo_read(rfr), .bit_clk_en(bce), .rx_overwrite(ovw), .irq(irq));
  sspi_peer u_peer (.pclk(pclk), .presetn(presetn), .push(push), .pop(pop), .active(act),
    .tx_level(txl), .fifo_stat(fst), .rx_frame_done(rfd), .rx_fifo_read(rfr),
    .slave_bit_tick(sbt));
  initial forever #2 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] stat_e();
    return {27'h0, act || txl != 4'h0, rxn == 8, rxn != 0, txl != 4'h8, txl == 4'h0};
  endfunction : stat_e
  function automatic logic [31:0] raw_e(input logic t);
    return {28'h0, txl <= 4'h4, rxn >= 4, t, ovr};
  endfunction : raw_e
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic pulse(input logic p);
    push <= p;
    pop <= !p;
    @(posedge pclk);
    push <= 1'b0;
    pop <= 1'b0;
    ovr = ovr | (p && rxn == 8);
    rxn = p ? (rxn == 8 ? 8 : rxn + 1) : (rxn > 0 ? rxn - 1 : 0);
    @(posedge pclk);
  endtask : pulse
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0, rd);
      chk(rd, re[i]);
      chk({31'h0, perr}, {31'h0, ra[i] == 32'h4004_0030});
    end
    $display("Reset values test done");
    // The first ten rounds fill the receive side past full with every enable off.
    for (int i = 0; i < 40; i++)
    begin
      txl <= 4'(rnd() % 9);
      act <= 1'(rnd());
      pulse(i < 10 || rnd() % 2 == 0);
      msk = (i < 10) ? 4'h0 : 4'(rnd());
      apb(1'b1, SSPI_MASK_OFF, {28'h0, msk}, rd);
      if (rnd() % 4 == 0)
      begin
        apb(1'b1, SSPI_CLR_OFF, 32'h1, rd);
        ovr = 1'b0;
      end
      apb(1'b1, SSPI_STAT_OFF, {27'h0, 5'(rnd())}, rd);
      apb(1'b0, SSPI_STAT_OFF, 32'h0, rd);
      chk(rd, stat_e());
      apb(1'b0, SSPI_RAW_OFF, 32'h0, rd);
      chk(rd, raw_e(1'b0));
      apb(1'b0, SSPI_MASKED_OFF, 32'h0, rd);
      chk(rd, raw_e(1'b0) & {28'h0, msk});
      chk({31'h0, irq}, {31'h0, |(raw_e(1'b0) & {28'h0, msk})});
    end
    $display("Status and interrupt test done");
    apb(1'b1, SSPI_PRESC_OFF, 32'h7, rd);
    apb(1'b0, SSPI_PRESC_OFF, 32'h0, rd);
    chk(rd, 32'h6);
    apb(1'b1, SSPI_CTRL0_OFF, 32'h100, rd);
    repeat (2) @(posedge pclk iff bce);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (!bce && n < 100);
    chk(32'(n), 32'hC);
    // Both modes tick every twelve clocks, so one pair of waits fits both.
    for (int m = 0; m < 2; m++)
    begin
      slave_mode <= 1'(m);
      pulse(1'b0);
      pulse(1'b1);
      apb(1'b1, SSPI_CLR_OFF, 32'h3, rd);
      ovr = 1'b0;
      repeat (300) @(posedge pclk);
      apb(1'b0, SSPI_RAW_OFF, 32'h0, rd);
      chk(rd, raw_e(1'b0));
      repeat (150) @(posedge pclk);
      apb(1'b0, SSPI_RAW_OFF, 32'h0, rd);
      chk(rd, raw_e(1'b1));
    end
    $display("Bit clock and time-out test done");
    end_of_test();
  end
  initial
  begin
    #40000 num_errors++;
    end_of_test();
  end
endmodule : spi_status_prescale_irq_tb
